// File: fsmc_pkg.sv
// Package of constants and types for the flash/SRAM host bus controller
// =====================================================================
// Behaviour
// - Flash read: reset high, enables low, write high
// - SRAM read: select one low, two high
// - Never both memories on the bus
// - Wait wake-up times after reset release
// - Flash write: select, write low, output high
// - SRAM write: select one, write low, output high
// - Write FFh before array reads
// - 90h enters configuration read until FFh
package fsmc_pkg;
	// =====================================================================
	// Register map of the controller (byte offsets)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_TIMING = 8'h14;
	// CTRL field positions
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int CTRL_SRAM_BIT = 2;
	localparam int CTRL_RESET_BIT = 3;
	// STATUS field positions
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WAKE_BIT = 1;
	localparam int STAT_RST_BIT = 2;
	// =====================================================================
	// Flash command codes and configuration addresses
	localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
	localparam logic [15:0] CMD_READ_CONFIG = 16'h0090;
	localparam logic [21:0] CFG_MAKER = 22'h000000;
	localparam logic [21:0] CFG_PART = 22'h000001;
	localparam logic [21:0] CFG_LOCK_OFS = 22'h000002;
	localparam logic [21:0] CFG_PROT_LOCK = 22'h000080;
	localparam logic [21:0] CFG_PROT_FIRST = 22'h000081;
	// =====================================================================
	// Timing: figures in ns and derived cycle counts at 50 MHz
	localparam int CLK_NS = 20;
	localparam int RESET_TO_OUTPUT_VALID_TIME_NS = 150;
	localparam int RESET_TO_WRITE_DELAY_NS = 150;
	localparam int WAKE_NS = (RESET_TO_OUTPUT_VALID_TIME_NS > RESET_TO_WRITE_DELAY_NS) ?
		RESET_TO_OUTPUT_VALID_TIME_NS : RESET_TO_WRITE_DELAY_NS;
	localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_LOW_NS = 100;
	localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] ACCESS_CYC_RESET = 8'h04;
	// =====================================================================
	// Carriers
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_n;
	} fsmc_flash_ctl_t;
	typedef struct packed {
		logic select_one_n;
		logic select_two;
		logic oe_n;
		logic we_n;
		logic upper_byte_n;
		logic lower_byte_n;
	} fsmc_sram_ctl_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD = 3'b011,
		ST_RESET = 3'b100,
		ST_WAKE = 3'b101
	} fsmc_state_t;
endpackage

// File: fsmc_host.sv
// Host controller driving the flash/SRAM package strobes from APB registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module fsmc_host #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory pins
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [DATA_W-1:0] mem_data_in,
	output logic [DATA_W-1:0] mem_data_out,
	output logic mem_data_oe,
	output fsmc_pkg::fsmc_flash_ctl_t flash_ctl,
	output fsmc_pkg::fsmc_sram_ctl_t sram_ctl
);
	// =====================================================================
	// Registers
	logic [ADDR_W-1:0] addr_q; // Target word address
	logic [DATA_W-1:0] wdata_q; // Data for the next write
	logic [DATA_W-1:0] rdata_q; // Last read result
	logic write_q; // Direction of the pending cycle
	logic sram_q; // Target memory: 1 selects SRAM
	logic [7:0] access_q; // Write strobe width in cycles; read strobes are three cycles longer, capped at 255
	logic go_q; // One-cycle start pulse from software
	logic reset_req_q; // One-cycle flash reset request
	logic [7:0] cnt_q; // Phase counter
	logic [DATA_W-1:0] sync1_q; // First synchroniser stage, read by sync2 only
	logic [DATA_W-1:0] sync2_q; // Second stage, safe to sample
	fsmc_pkg::fsmc_state_t state_q;
	logic busy;
	logic apb_wr;
	logic apb_rd_ok;

	assign busy = (state_q != fsmc_pkg::ST_IDLE);
	assign apb_wr = psel && penable && pwrite;
	// =====================================================================
	// APB slave: zero-wait, unmapped addresses answer with an error
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == fsmc_pkg::REG_CTRL) || (a == fsmc_pkg::REG_ADDR) ||
			(a == fsmc_pkg::REG_WDATA) || (a == fsmc_pkg::REG_RDATA) ||
			(a == fsmc_pkg::REG_STATUS) || (a == fsmc_pkg::REG_TIMING);
	endfunction
	assign apb_rd_ok = mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_rd_ok;

	// Read mux; data outputs come from flip-flops elsewhere, this is the bus view
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			fsmc_pkg::REG_CTRL: prdata = {29'h0, reset_req_q, sram_q, write_q} << 1;
			fsmc_pkg::REG_ADDR: prdata = 32'(addr_q);
			fsmc_pkg::REG_WDATA: prdata = 32'(wdata_q);
			fsmc_pkg::REG_RDATA: prdata = 32'(rdata_q);
			fsmc_pkg::REG_STATUS: begin
				prdata[fsmc_pkg::STAT_BUSY_BIT] = busy;
				prdata[fsmc_pkg::STAT_WAKE_BIT] = (state_q == fsmc_pkg::ST_WAKE);
				prdata[fsmc_pkg::STAT_RST_BIT] = (state_q == fsmc_pkg::ST_RESET);
			end
			fsmc_pkg::REG_TIMING: prdata = 32'(access_q);
			default: prdata = 32'h0000_0000;
		endcase
	end

	// Software settings; ignored while a cycle is running
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= '0;
			wdata_q <= '0;
			write_q <= 1'b0;
			sram_q <= 1'b0;
			access_q <= fsmc_pkg::ACCESS_CYC_RESET;
		end else if (apb_wr && !busy) begin
			unique case (paddr)
				fsmc_pkg::REG_CTRL: begin
					write_q <= pwdata[fsmc_pkg::CTRL_WRITE_BIT];
					sram_q <= pwdata[fsmc_pkg::CTRL_SRAM_BIT];
				end
				fsmc_pkg::REG_ADDR: addr_q <= pwdata[ADDR_W-1:0];
				// Mode commands such as FFh and 90h are plain write data
				fsmc_pkg::REG_WDATA: wdata_q <= pwdata[DATA_W-1:0];
				// Zero width would wrap the counter to a 256-cycle write strobe, so clamp to one
				fsmc_pkg::REG_TIMING: access_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Start pulses from the control register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			go_q <= 1'b0;
			reset_req_q <= 1'b0;
		end else begin
			go_q <= apb_wr && !busy && (paddr == fsmc_pkg::REG_CTRL) && pwdata[fsmc_pkg::CTRL_GO_BIT];
			reset_req_q <= apb_wr && !busy && (paddr == fsmc_pkg::REG_CTRL) && pwdata[fsmc_pkg::CTRL_RESET_BIT];
		end
	end

	// Read data crosses from the pins through two flops
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= mem_data_in;
			sync2_q <= sync1_q;
		end
	end

	// =====================================================================
	// Cycle sequencer. Setup, strobe, hold; the synchroniser adds two cycles
	// of latency, so reads are captured at the end of a stretched strobe.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= fsmc_pkg::ST_RESET; // Pulse flash reset at power-up
			cnt_q <= 8'(fsmc_pkg::RESET_LOW_CYC);
		end else begin
			unique case (state_q)
				fsmc_pkg::ST_IDLE: begin
					if (reset_req_q) begin
						state_q <= fsmc_pkg::ST_RESET;
						cnt_q <= 8'(fsmc_pkg::RESET_LOW_CYC);
					end else if (go_q) begin
						state_q <= fsmc_pkg::ST_SETUP;
						cnt_q <= 8'h01;
					end
				end
				fsmc_pkg::ST_SETUP: begin
					// Address settles before any strobe falls
					state_q <= fsmc_pkg::ST_STROBE;
					// Reads need three extra cycles: one for the registered output enable,
					// two for the synchroniser, so even a one-cycle setting returns real data
					if (write_q) begin
						cnt_q <= access_q;
					end else if (access_q > 8'hFC) begin
						cnt_q <= 8'hFF; // Saturate instead of wrapping to a short strobe
					end else begin
						cnt_q <= access_q + 8'h03;
					end
				end
				fsmc_pkg::ST_STROBE: begin
					if (cnt_q == 8'h01) begin
						state_q <= fsmc_pkg::ST_HOLD;
						cnt_q <= 8'h01;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				fsmc_pkg::ST_HOLD: begin
					// Strobes are high again; data and address still held
					state_q <= fsmc_pkg::ST_IDLE;
				end
				fsmc_pkg::ST_RESET: begin
					// Any running program or erase is aborted by this
					if (cnt_q == 8'h01) begin
						state_q <= fsmc_pkg::ST_WAKE;
						cnt_q <= 8'(fsmc_pkg::WAKE_CYC);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				fsmc_pkg::ST_WAKE: begin
					// No access until output-valid and write delays pass
					if (cnt_q == 8'h01) begin
						state_q <= fsmc_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: state_q <= fsmc_pkg::ST_IDLE;
			endcase
		end
	end

	// Read data captured at the last strobe cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= '0;
		end else if (state_q == fsmc_pkg::ST_STROBE && cnt_q == 8'h01 && !write_q) begin
			rdata_q <= sync2_q;
		end
	end

	// =====================================================================
	// Pin drivers, all registered
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flash_ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0};
			sram_ctl <= '{select_one_n: 1'b1, select_two: 1'b0, oe_n: 1'b1, we_n: 1'b1,
				upper_byte_n: 1'b1, lower_byte_n: 1'b1};
			mem_addr <= '0;
			mem_data_out <= '0;
			mem_data_oe <= 1'b0;
		end else begin
			// Default: both parts deselected, bus floats
			flash_ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1};
			sram_ctl <= '{select_one_n: 1'b1, select_two: 1'b0, oe_n: 1'b1, we_n: 1'b1,
				upper_byte_n: 1'b1, lower_byte_n: 1'b1};
			mem_data_oe <= 1'b0;
			mem_addr <= addr_q;
			mem_data_out <= wdata_q;
			if (state_q == fsmc_pkg::ST_RESET) begin
				flash_ctl.reset_n <= 1'b0; // Flash held in reset
			end else if ((state_q == fsmc_pkg::ST_SETUP || state_q == fsmc_pkg::ST_STROBE ||
				state_q == fsmc_pkg::ST_HOLD) && !sram_q) begin
				// Only the flash is selected; SRAM stays deselected
				flash_ctl.ce_n <= (state_q == fsmc_pkg::ST_HOLD);
				mem_data_oe <= write_q;
				if (state_q == fsmc_pkg::ST_STROBE) begin
					flash_ctl.oe_n <= write_q; // Read strobe
					flash_ctl.we_n <= !write_q; // Write strobe, OE high
				end
			end else if (state_q == fsmc_pkg::ST_SETUP || state_q == fsmc_pkg::ST_STROBE ||
				state_q == fsmc_pkg::ST_HOLD) begin
				// Only the SRAM is selected; flash stays deselected
				sram_ctl.select_one_n <= (state_q == fsmc_pkg::ST_HOLD);
				sram_ctl.select_two <= (state_q != fsmc_pkg::ST_HOLD);
				sram_ctl.upper_byte_n <= 1'b0;
				sram_ctl.lower_byte_n <= 1'b0;
				mem_data_oe <= write_q;
				if (state_q == fsmc_pkg::ST_STROBE) begin
					sram_ctl.oe_n <= write_q;
					sram_ctl.we_n <= !write_q;
				end
			end
		end
	end
endmodule

// File: fsmc_host_sva.sv
// Checker of the host controller's strobe discipline on the memory pins
`timescale 1ns/100ps
module fsmc_host_sva #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pslverr,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [DATA_W-1:0] mem_data_out,
	input wire logic mem_data_oe,
	input wire fsmc_pkg::fsmc_flash_ctl_t flash_ctl,
	input wire fsmc_pkg::fsmc_sram_ctl_t sram_ctl
);
	// =====================================================================
	// Strobe relations, all in the one clock domain
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_FLASH_READ: assert property (!flash_ctl.oe_n |-> !flash_ctl.ce_n && flash_ctl.we_n && flash_ctl.reset_n)
		else $error("flash read strobes wrong");
	AST_SRAM_READ: assert property (!sram_ctl.oe_n |-> !sram_ctl.select_one_n && sram_ctl.select_two && sram_ctl.we_n)
		else $error("sram read strobes wrong");
	// Flash cycle in progress keeps the SRAM off the bus
	AST_NO_CONTENTION: assert property (!flash_ctl.oe_n || !flash_ctl.we_n |-> sram_ctl.oe_n && sram_ctl.we_n)
		else $error("both memories active");
	AST_HOST_DRIVES_ONLY_WRITES: assert property (mem_data_oe |-> flash_ctl.oe_n && sram_ctl.oe_n)
		else $error("host drives bus during read");
	// Wake-up gap after flash reset release, 150 ns is 8 cycles
	AST_WAKE_GAP: assert property ($rose(flash_ctl.reset_n) |-> (flash_ctl.ce_n && flash_ctl.we_n)[*8])
		else $error("flash accessed during wake-up");
	AST_FLASH_WRITE: assert property (!flash_ctl.we_n |-> !flash_ctl.ce_n && flash_ctl.oe_n && flash_ctl.reset_n)
		else $error("flash write strobes wrong");
	// Data and address must still stand when the flash write strobe rises
	AST_WDATA_HELD: assert property ($rose(flash_ctl.we_n) |-> mem_data_oe && $stable(mem_data_out) && $stable(mem_addr))
		else $error("write data not held to strobe end");
	AST_SRAM_WRITE: assert property (!sram_ctl.we_n |-> !sram_ctl.select_one_n && sram_ctl.oe_n && sram_ctl.select_two)
		else $error("sram write strobes wrong");
	// =====================================================================
	// Main scenarios reached
	COV_FREAD: cover property (!flash_ctl.oe_n);
	COV_SWRITE: cover property (!sram_ctl.we_n);
	COV_FRESET: cover property ($rose(flash_ctl.reset_n));
	COV_SLVERR: cover property (pslverr);
endmodule
bind fsmc_host fsmc_host_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva(.sys_clk, .reset_n, .pslverr, .mem_addr,
	.mem_data_out, .mem_data_oe, .flash_ctl, .sram_ctl);

// File: fsmc_mem_model.sv
// Behavioural model of the flash plus SRAM package on the shared bus
`timescale 1ns/100ps
module fsmc_mem_model #(
	parameter logic [15:0] MAKER_ID = 16'h5A3C, // Arbitrary value
	parameter logic [15:0] PART_ID = 16'h2E71 // Arbitrary value
) (
	input wire logic [21:0] addr,
	input wire logic [15:0] bus,
	output logic [15:0] dq,
	input wire fsmc_pkg::fsmc_flash_ctl_t fc,
	input wire fsmc_pkg::fsmc_sram_ctl_t sc
);
	logic cfg_q; // Configuration read mode
	logic [15:0] sram_q [0:15];
	logic [15:0] rd_val;
	logic [15:0] park; // Last driven value, inverted when released
	wire f_wr = fc.reset_n & ~fc.ce_n & ~fc.we_n & fc.oe_n;
	wire s_wr = ~sc.select_one_n & sc.select_two & ~sc.we_n & sc.oe_n;
	// Drive only in a read cycle; float in reset, standby, output disable
	wire f_drv = fc.reset_n & ~fc.ce_n & ~fc.oe_n & fc.we_n;
	wire s_drv = ~sc.select_one_n & sc.select_two & ~sc.oe_n & sc.we_n;
	// =====================================================================
	// Command capture at the first rising strobe, no memory location used
	always @(negedge f_wr or negedge fc.reset_n) begin
		if (!fc.reset_n) begin
			cfg_q <= 1'b0; // Back in array read, blocks locked
		end else if (bus === fsmc_pkg::CMD_READ_CONFIG) begin
			cfg_q <= 1'b1;
		end else if (bus === fsmc_pkg::CMD_READ_ARRAY) begin
			cfg_q <= 1'b0;
		end
	end
	always @(negedge s_wr) begin
		sram_q[addr[3:0]] <= bus;
	end
	// Read path, no supply level involved
	always_comb begin
		if (s_drv) rd_val = sram_q[addr[3:0]];
		else if (!cfg_q) rd_val = 16'hA500 ^ addr[15:0];
		else if (addr == 22'h0) rd_val = MAKER_ID;
		else if (addr == 22'h1) rd_val = PART_ID;
		else if (addr[11:0] == 12'h002) rd_val = 16'h0001; // Locked since reset
		else if (addr == 22'h80) rd_val = 16'h0001;
		else if (addr >= 22'h81 && addr <= 22'h88) rd_val = 16'h6000 + addr[15:0];
		else rd_val = 16'h0000; // Reserved, no meaning
	end
	// A released bus shows no stale value, so the simulator cannot hide a late sample
	always @(rd_val or f_drv or s_drv) begin
		if (f_drv || s_drv) park = rd_val;
	end
	assign dq = (f_drv || s_drv) ? rd_val : ~park;
endmodule

// File: fsmc_host_tb.sv
// Self-checking testbench of the flash/SRAM host controller
`timescale 1ns/100ps
module fsmc_host_tb;
	localparam logic [15:0] MAKER = 16'h5A3C; // Arbitrary value
	localparam logic [15:0] PART = 16'h2E71; // Arbitrary value
	logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, mem_data_oe, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [21:0] mem_addr;
	logic [15:0] mem_data_out, m_dq;
	wire [15:0] bus = mem_data_oe ? mem_data_out : m_dq; // Shared data bus
	fsmc_pkg::fsmc_flash_ctl_t flash_ctl;
	fsmc_pkg::fsmc_sram_ctl_t sram_ctl;
	int n_mismatch, n_checks, cyc;
	fsmc_host u_dut(.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
		.mem_data_in(bus), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .flash_ctl(flash_ctl),
		.sram_ctl(sram_ctl));
	fsmc_mem_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_mem(.addr(mem_addr), .bus(bus), .dq(m_dq),
		.fc(flash_ctl), .sc(sram_ctl));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Hang guard: the whole run needs some 730 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// =====================================================================
	// APB transfer; entered just after a rising edge, idle edge at the end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic idle();
		do apb(1'b0, fsmc_pkg::REG_STATUS, 32'h0); while (rdv[2:0] !== 3'b000);
	endtask
	// One memory cycle; reads leave the word in rdv
	task automatic mem(input logic w, input logic s, input logic [21:0] a, input logic [15:0] d);
		apb(1'b1, fsmc_pkg::REG_ADDR, {10'h000, a});
		apb(1'b1, fsmc_pkg::REG_WDATA, {16'h0000, d});
		apb(1'b1, fsmc_pkg::REG_CTRL, {29'h0, s, w, 1'b1});
		idle();
		if (!w) apb(1'b0, fsmc_pkg::REG_RDATA, 32'h0);
	endtask
	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{n_mismatch, n_checks, cyc} = '0;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// Register reset value, unmapped address refused
		apb(1'b0, fsmc_pkg::REG_TIMING, 32'h0);
		chk(rdv, 32'h0000_0004);
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rdv[30:0]}, 32'h8000_0000);
		idle();
		mem(1'b0, 1'b0, 22'h5, 16'h0); chk(rdv, 32'h0000_A505);
		// Configuration space, SRAM traffic in between
		mem(1'b1, 1'b0, 22'h0, 16'h0090);
		mem(1'b0, 1'b0, 22'h0, 16'h0); chk(rdv, {16'h0, MAKER});
		mem(1'b0, 1'b0, 22'h1, 16'h0); chk(rdv, {16'h0, PART});
		mem(1'b1, 1'b1, 22'h3, 16'hBEEF);
		mem(1'b0, 1'b1, 22'h3, 16'h0); chk(rdv, 32'h0000_BEEF);
		mem(1'b0, 1'b0, 22'h1002, 16'h0); chk(rdv, 32'h1);
		mem(1'b0, 1'b0, 22'h80, 16'h0); chk(rdv, 32'h1);
		for (int i = 8'h81; i <= 8'h88; i++) begin
			mem(1'b0, 1'b0, 22'(i), 16'h0); chk(rdv, 32'h6000 + i);
		end
		mem(1'b1, 1'b0, 22'h0, 16'h00FF);
		mem(1'b0, 1'b0, 22'h0, 16'h0); chk(rdv, 32'h0000_A500);
		// Strobe lengths of 1, 4 and 7 cycles in the timing field
		for (int t = 1; t <= 8; t += 3) begin
			apb(1'b1, fsmc_pkg::REG_TIMING, 32'(t));
			mem(1'b1, 1'b1, 22'(t), 16'h1100 + 16'(t));
			mem(1'b0, 1'b0, 22'(t), 16'h0); chk(rdv, 32'hA500 ^ t);
			mem(1'b0, 1'b1, 22'(t), 16'h0); chk(rdv, 32'h1100 + t);
		end
		// Flash reset from configuration mode returns to array reads
		mem(1'b1, 1'b0, 22'h0, 16'h0090);
		apb(1'b1, fsmc_pkg::REG_CTRL, 32'h0000_0008);
		apb(1'b0, fsmc_pkg::REG_STATUS, 32'h0); chk({31'h0, |rdv[2:1]}, 32'h1);
		idle();
		mem(1'b0, 1'b0, 22'h2, 16'h0); chk(rdv, 32'h0000_A502);
		wrap_up();
	end
endmodule
